// ==== hdl/css_consts.svh ====
// Purpose: constants of the CANopen slave supervision block
// Assumes: hclk at 250 MHz, AHB-Lite byte addresses
// Notes:   offsets are word aligned, only bits [7:2] decoded
// Summary of operation
// - reset-node command sets flag, software clears it
// - internal error sends emergency, configurable identifier
// - emergency has eight bytes: code, register, extra
// - codes 1000/2100/2300/3200/4000 with register bits
// - missing guard gives code 8100, bit 4
// - missing sync gives code 8200, bit 4
// - wire-break bytes 3..5 map outputs 0..23
// - short-circuit bytes 3..5 map outputs 0..23
// - node number accepted only from 1 to 30
// - new node number re-derives default identifiers of objects 1 and 2
// - node number kept until set again
// - guard interval zero disables, else milliseconds
// - lifetime counts missed guard intervals before failure
// - sync interval zero disables, else milliseconds
// - missing guard or sync sets error flag
// - sync pulse flag high exactly one cycle
// - objects 1..8, custom identifiers from 380 hex
// - type 0..240 synchronous, 255 asynchronous
// - type n sends once per n syncs
// - inhibit delay 0..65535 ms per object
// - inhibit running holds back next transmission
// - objects default asynchronous, sent on change
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CSS_A_CTRL   8'h00
`define CSS_A_NODE   8'h04
`define CSS_A_GUARD  8'h08
`define CSS_A_SYNC   8'h0C
`define CSS_A_STAT   8'h10
`define CSS_A_EMCYID 8'h14
`define CSS_A_TXCFG  8'h18
`define CSS_A_TXINH  8'h1C
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define CSS_NODE_RST 6'h20
`define CSS_NODE_MIN 6'h01
`define CSS_NODE_MAX 6'h1E
`define CSS_EMCY_RST 11'h0A0
`define CSS_ID_MIN   11'h380
`define CSS_ID_T1    11'h180
`define CSS_ID_T2    11'h280
`define CSS_ID_TN    11'h388
`define CSS_TT_ASYNC 8'hFF
`define CSS_TT_MAX   8'hF0
// ----------------------------------------
// Emergency codes and timing
// ----------------------------------------
`define CSS_EC_GEN   16'h1000
`define CSS_EC_WIRE  16'h2100
`define CSS_EC_SHORT 16'h2300
`define CSS_EC_SUPP  16'h3200
`define CSS_EC_TEMP  16'h4000
`define CSS_EC_GUARD 16'h8100
`define CSS_EC_SYNC  16'h8200
`define CSS_MS_NS    1000000
`define CSS_CLK_NS   4
`define CSS_MS_CYC   (`CSS_MS_NS / `CSS_CLK_NS)
`endif

// ==== hdl/css_pkg.sv ====
// Purpose: types of the CANopen slave supervision block
// Assumes: constants live in css_consts.svh
// Notes:   structs carry the outgoing messages
`default_nettype none
package css_pkg;
   typedef enum logic [1:0] {BUS_ADDR = 2'b01, BUS_DATA = 2'b10} css_bus_e;
   typedef struct packed {
      logic [10:0] id;
      logic [63:0] data;
   } css_emcy_s;
   typedef struct packed {
      logic [2:0]  idx;
      logic [10:0] id;
   } css_txreq_s;
endpackage
`default_nettype wire

// ==== hdl/css_supervision.sv ====
// Purpose: CANopen slave supervision, emergency and transmit objects
// Assumes: CAN framing outside; event inputs are one-cycle pulses
// Notes:   every AHB access takes one wait state
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "css_consts.svh"

module css_supervision #(
   parameter int MS_CYC = `CSS_MS_CYC
) (
   // Clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // AHB-Lite slave
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic                  hreadyout,
   output logic                  hresp,
   output logic [31:0]           hrdata,
   // Network events
   input  wire logic             nmt_reset_cmd,
   input  wire logic             guard_rx,
   input  wire logic             sync_rx,
   // Error sources
   input  wire logic             err_general,
   input  wire logic             err_supply,
   input  wire logic             err_overtemp,
   input  wire logic [23:0]      wire_break,
   input  wire logic [23:0]      short_circ,
   // Transmit object data changes
   input  wire logic [7:0]       tx_change,
   // Emergency message out
   output logic                  emcy_valid,
   output css_pkg::css_emcy_s    emcy_msg,
   input  wire logic             emcy_ready,
   // Transmit request out
   output logic                  tx_valid,
   output css_pkg::css_txreq_s   tx_req,
   input  wire logic             tx_ready,
   // Application flags
   output logic                  reset_node_request_flag,
   output logic                  software_restart_call,
   output logic                  guard_timeout_error,
   output logic                  sync_timeout_error,
   output logic                  sync_pulse_flag,
   output logic [7:0]            error_register,
   output logic [5:0]            node_number
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   css_pkg::css_bus_e  st_q, st_d;
   logic [7:0]         a_q, a_d;
   logic               w_q, w_d, rdy_q, rdy_d, wr;
   logic [31:0]        rd_q, rd_d, rmux;
   logic               rnr_q, rnr_d, rst_q, rst_d, sp_q, sp_d;
   logic [5:0]         node_q, node_d;
   logic [15:0]        gint_q, gint_d, sint_q, sint_d;
   logic [7:0]         life_q, life_d, lim;
   logic [10:0]        eid_q, eid_d;
   logic [17:0]        tc_q, tc_d;
   logic               tick_q, tick_d;
   logic [15:0]        gc_q, gc_d, sc_q, sc_d;
   logic [7:0]         gm_q, gm_d;
   logic               gerr_q, gerr_d, serr_q, serr_d;
   logic [6:0]         cond, nw, cp_q, pe_q, pe_d;
   logic [23:0]        wb_q, sh_q;
   logic [7:0]         er_q, er_d;
   logic               ev_q, ev_d;
   css_pkg::css_emcy_s em_q, em_d;
   logic [10:0]        tid_q [8];
   logic [10:0]        tid_d [8];
   logic [7:0]         tt_q [8];
   logic [7:0]         tt_d [8];
   logic [7:0]         sn_q [8];
   logic [7:0]         sn_d [8];
   logic [15:0]        inh_q [8];
   logic [15:0]        inh_d [8];
   logic [15:0]        ic_q [8];
   logic [15:0]        ic_d [8];
   logic [7:0]         cu_q, cu_d, pn_q, pn_d, du_q, du_d, trdy;
   logic [2:0]         tsel_q, tsel_d;
   logic               tv_q, tv_d;
   css_pkg::css_txreq_s tr_q, tr_d;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Word decode shared by reads and writes
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a[7:2] == off[7:2];
   endfunction

   function automatic logic [15:0] ecode(input logic [2:0] k);
      case (k)
         3'h0:    ecode = `CSS_EC_GEN;
         3'h1:    ecode = `CSS_EC_WIRE;
         3'h2:    ecode = `CSS_EC_SHORT;
         3'h3:    ecode = `CSS_EC_SUPP;
         3'h4:    ecode = `CSS_EC_TEMP;
         3'h5:    ecode = `CSS_EC_GUARD;
         default: ecode = `CSS_EC_SYNC;
      endcase
   endfunction

   // default identifiers of objects 0 and 1 follow the node number
   function automatic logic [10:0] tid_eff(input logic [2:0] k);
      if (cu_q[k])
         return tid_q[k];
      else if (k == 3'h0)
         return `CSS_ID_T1 + {5'h00, node_q};
      else if (k == 3'h1)
         return `CSS_ID_T2 + {5'h00, node_q};
      else
         return `CSS_ID_TN + {8'h00, k};
   endfunction

   // ----------------------------------------
   // AHB-Lite slave
   // ----------------------------------------
   assign wr = (st_q == css_pkg::BUS_DATA) && w_q;

   // Read mux, unmapped words read zero
   always_comb begin
      rmux = 32'h0000_0000;
      if (hit(a_q, `CSS_A_CTRL))   rmux = {31'h0, rnr_q};
      if (hit(a_q, `CSS_A_NODE))   rmux = {26'h0, node_q};
      if (hit(a_q, `CSS_A_GUARD))  rmux = {8'h00, life_q, gint_q};
      if (hit(a_q, `CSS_A_SYNC))   rmux = {16'h0000, sint_q};
      if (hit(a_q, `CSS_A_STAT))   rmux = {16'h0000, er_q, 6'h00, serr_q, gerr_q};
      if (hit(a_q, `CSS_A_EMCYID)) rmux = {21'h0, eid_q};
      if (hit(a_q, `CSS_A_TXCFG))  rmux = {8'h00, tt_q[tsel_q], 1'b0, tsel_q, 1'b0, tid_eff(tsel_q)};
      if (hit(a_q, `CSS_A_TXINH))  rmux = {13'h0, tsel_q, inh_q[tsel_q]};
   end

   // Wait state lets read data come from a flop
   always_comb begin
      st_d  = st_q;
      a_d   = a_q;
      w_d   = w_q;
      rdy_d = rdy_q;
      rd_d  = rd_q;
      unique case (st_q)
         css_pkg::BUS_ADDR: begin
            if (hsel && htrans[1] && hready) begin
               st_d  = css_pkg::BUS_DATA;
               a_d   = haddr[7:0];
               w_d   = hwrite;
               rdy_d = 1'b0;
            end
         end
         css_pkg::BUS_DATA: begin
            st_d  = css_pkg::BUS_ADDR;
            rdy_d = 1'b1;
            if (!w_q) rd_d = rmux;
         end
         default: begin
            st_d  = css_pkg::BUS_ADDR;
            rdy_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q  <= css_pkg::BUS_ADDR;
         a_q   <= 8'h00;
         w_q   <= 1'b0;
         rdy_q <= 1'b1;
         rd_q  <= 32'h0000_0000;
      end else begin
         st_q  <= st_d;
         a_q   <= a_d;
         w_q   <= w_d;
         rdy_q <= rdy_d;
         rd_q  <= rd_d;
      end
   end

   assign hreadyout = rdy_q;
   assign hresp     = 1'b0;
   assign hrdata    = rd_q;

   // ----------------------------------------
   // Configuration and application flags
   // ----------------------------------------
   always_comb begin
      // set wins over the software clear
      rnr_d  = nmt_reset_cmd | (rnr_q & ~(wr && hit(a_q, `CSS_A_CTRL) && hwdata[0]));
      rst_d  = wr && hit(a_q, `CSS_A_CTRL) && hwdata[1];
      sp_d   = sync_rx;
      node_d = node_q;
      gint_d = gint_q;
      life_d = life_q;
      sint_d = sint_q;
      eid_d  = eid_q;
      if (wr && hit(a_q, `CSS_A_NODE) && hwdata[5:0] >= `CSS_NODE_MIN && hwdata[5:0] <= `CSS_NODE_MAX &&
          hwdata[31:6] == 26'h0)
         node_d = hwdata[5:0];
      if (wr && hit(a_q, `CSS_A_GUARD)) begin
         gint_d = hwdata[15:0];
         life_d = hwdata[23:16];
      end
      if (wr && hit(a_q, `CSS_A_SYNC)) sint_d = hwdata[15:0];
      if (wr && hit(a_q, `CSS_A_EMCYID)) eid_d = hwdata[10:0];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rnr_q  <= 1'b0;
         rst_q  <= 1'b0;
         sp_q   <= 1'b0;
         node_q <= `CSS_NODE_RST;
         gint_q <= 16'h0000;
         life_q <= 8'h00;
         sint_q <= 16'h0000;
         eid_q  <= `CSS_EMCY_RST;
      end else begin
         rnr_q  <= rnr_d;
         rst_q  <= rst_d;
         sp_q   <= sp_d;
         node_q <= node_d;
         gint_q <= gint_d;
         life_q <= life_d;
         sint_q <= sint_d;
         eid_q  <= eid_d;
      end
   end

   assign reset_node_request_flag = rnr_q;
   assign software_restart_call   = rst_q;
   assign sync_pulse_flag         = sp_q;
   assign node_number             = node_q;

   // ----------------------------------------
   // Millisecond tick and timeout monitors
   // ----------------------------------------
   always_comb begin
      tick_d = tc_q == 18'(MS_CYC - 1);
      tc_d   = tick_d ? 18'h00000 : tc_q + 18'h00001;
      // Lifetime zero still allows one interval
      lim    = (life_q == 8'h00) ? 8'h01 : life_q;
      gc_d   = gc_q;
      gm_d   = gm_q;
      sc_d   = sc_q;
      gerr_d = gerr_q & ~(wr && hit(a_q, `CSS_A_STAT) && hwdata[0]);
      serr_d = serr_q & ~(wr && hit(a_q, `CSS_A_STAT) && hwdata[1]);
      // count missed intervals, saturating at 255; error once lifetime is reached
      if (guard_rx) begin
         gc_d = 16'h0000;
         gm_d = 8'h00;
      end else if (tick_q && gint_q != 16'h0000) begin
         if (gc_q + 16'h0001 >= gint_q) begin
            gc_d = 16'h0000;
            if (gm_q != 8'hFF) gm_d = gm_q + 8'h01;
            if (gm_q + 8'h01 >= lim) gerr_d = 1'b1;
         end else begin
            gc_d = gc_q + 16'h0001;
         end
      end
      // sync monitor off at zero interval
      if (sync_rx) begin
         sc_d = 16'h0000;
      end else if (tick_q && sint_q != 16'h0000) begin
         if (sc_q + 16'h0001 >= sint_q) begin
            sc_d   = 16'h0000;
            serr_d = 1'b1;
         end else begin
            sc_d = sc_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tc_q   <= 18'h00000;
         tick_q <= 1'b0;
         gc_q   <= 16'h0000;
         gm_q   <= 8'h00;
         sc_q   <= 16'h0000;
         gerr_q <= 1'b0;
         serr_q <= 1'b0;
      end else begin
         tc_q   <= tc_d;
         tick_q <= tick_d;
         gc_q   <= gc_d;
         gm_q   <= gm_d;
         sc_q   <= sc_d;
         gerr_q <= gerr_d;
         serr_q <= serr_d;
      end
   end

   assign guard_timeout_error = gerr_q;
   assign sync_timeout_error  = serr_q;

   // ----------------------------------------
   // Emergency messages
   // ----------------------------------------
   always_comb begin
      cond  = {serr_q, gerr_q, err_overtemp, err_supply, |short_circ, |wire_break, err_general};
      // only fresh conditions or fresh output bits
      nw    = cond & ~cp_q;
      nw[1] = nw[1] | (|(wire_break & ~wb_q));
      nw[2] = nw[2] | (|(short_circ & ~sh_q));
      // error register bits 0..3; bit 4
      er_d  = {3'b000, cond[5] | cond[6], cond[4], cond[3], cond[1] | cond[2], cond[0]};
      pe_d  = pe_q | nw;
      ev_d  = ev_q & ~emcy_ready;
      em_d  = em_q;
      if (!ev_d) begin
         for (int k = 6; k >= 0; k--) begin
            if (pe_q[k]) begin
               em_d.id         = eid_q;
               em_d.data       = 64'h0;
               em_d.data[15:0] = ecode(3'(k));
               em_d.data[23:16] = er_d;
               if (k == 1) em_d.data[47:24] = wire_break;
               if (k == 2) em_d.data[47:24] = short_circ;
               if (k == 6) em_d.data[31:24] = 8'h02;
            end
         end
         if (pe_q != 7'h00) begin
            ev_d = 1'b1;
            pe_d = (pe_q & (pe_q - 7'h01)) | nw;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cp_q <= 7'h00;
         wb_q <= 24'h000000;
         sh_q <= 24'h000000;
         pe_q <= 7'h00;
         er_q <= 8'h00;
         ev_q <= 1'b0;
         em_q <= '0;
      end else begin
         cp_q <= cond;
         wb_q <= wire_break;
         sh_q <= short_circ;
         pe_q <= pe_d;
         er_q <= er_d;
         ev_q <= ev_d;
         em_q <= em_d;
      end
   end

   assign emcy_valid     = ev_q;
   assign emcy_msg       = em_q;
   assign error_register = er_q;

   // ----------------------------------------
   // Transmit objects
   // ----------------------------------------
   always_comb begin
      tid_d  = tid_q;
      tt_d   = tt_q;
      sn_d   = sn_q;
      inh_d  = inh_q;
      ic_d   = ic_q;
      cu_d   = cu_q;
      du_d   = du_q;
      tsel_d = tsel_q;
      tv_d   = tv_q & ~tx_ready;
      tr_d   = tr_q;
      pn_d   = pn_q | tx_change;
      trdy   = 8'h00;
      // custom identifiers below 380 hex refused
      if (wr && hit(a_q, `CSS_A_TXCFG)) begin
         tsel_d = hwdata[14:12];
         if (hwdata[10:0] >= `CSS_ID_MIN) begin
            tid_d[hwdata[14:12]] = hwdata[10:0];
            cu_d[hwdata[14:12]]  = 1'b1;
         end
         if (hwdata[23:16] <= `CSS_TT_MAX || hwdata[23:16] == `CSS_TT_ASYNC) begin
            tt_d[hwdata[14:12]] = hwdata[23:16];
            sn_d[hwdata[14:12]] = 8'h00;
         end
      end
      if (wr && hit(a_q, `CSS_A_TXINH)) begin
         tsel_d               = hwdata[18:16];
         inh_d[hwdata[18:16]] = hwdata[15:0];
      end
      for (int i = 0; i < 8; i++) begin
         // delay frozen while the offer waits, so it runs from the take
         if (tick_q && ic_q[i] != 16'h0000 && !(tv_q && tr_q.idx == 3'(i))) ic_d[i] = ic_q[i] - 16'h0001;
         // cyclic types send every n-th sync
         if (sync_rx && tt_q[i] != `CSS_TT_ASYNC) begin
            if (tt_q[i] == 8'h00) begin
               if (pn_q[i] | tx_change[i]) du_d[i] = 1'b1;
            end else if (sn_q[i] + 8'h01 >= tt_q[i]) begin
               sn_d[i] = 8'h00;
               du_d[i] = 1'b1;
            end else begin
               sn_d[i] = sn_q[i] + 8'h01;
            end
         end
         trdy[i] = (tt_q[i] == `CSS_TT_ASYNC) ? pn_q[i] && ic_q[i] == 16'h0000 : du_q[i];
      end
      if (!tv_d) begin
         for (int k = 7; k >= 0; k--) begin
            if (trdy[k]) begin
               tr_d.idx = 3'(k);
               tr_d.id  = tid_eff(3'(k));
            end
         end
         if (trdy != 8'h00) begin
            tv_d = 1'b1;
            pn_d[tr_d.idx] = tx_change[tr_d.idx];
            du_d[tr_d.idx] = 1'b0;
            if (tt_q[tr_d.idx] == `CSS_TT_ASYNC) ic_d[tr_d.idx] = inh_q[tr_d.idx];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 8; i++) begin
            tid_q[i] <= 11'h000;
            tt_q[i]  <= `CSS_TT_ASYNC;
            sn_q[i]  <= 8'h00;
            inh_q[i] <= 16'h0000;
            ic_q[i]  <= 16'h0000;
         end
         cu_q   <= 8'h00;
         pn_q   <= 8'h00;
         du_q   <= 8'h00;
         tsel_q <= 3'h0;
         tv_q   <= 1'b0;
         tr_q   <= '0;
      end else begin
         tid_q  <= tid_d;
         tt_q   <= tt_d;
         sn_q   <= sn_d;
         inh_q  <= inh_d;
         ic_q   <= ic_d;
         cu_q   <= cu_d;
         pn_q   <= pn_d;
         du_q   <= du_d;
         tsel_q <= tsel_d;
         tv_q   <= tv_d;
         tr_q   <= tr_d;
      end
   end

   assign tx_valid = tv_q;
   assign tx_req   = tr_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_lone_sync;
      sync_rx ##1 !sync_rx;
   endsequence
   property p_sync_pulse;
      s_lone_sync |-> sync_pulse_flag ##1 !sync_pulse_flag;
   endproperty
   a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse not one cycle");
   property p_rnr_set;
      nmt_reset_cmd |=> reset_node_request_flag;
   endproperty
   a_rnr_set: assert property (p_rnr_set) else $error("reset-node flag not set");
   property p_node_range;
      $changed(node_number) |-> node_number >= 6'h01 && node_number <= 6'h1E;
   endproperty
   a_node_range: assert property (p_node_range) else $error("node number out of range");
   property p_guard_off;
      $rose(guard_timeout_error) |-> $past(gint_q) != 16'h0000;
   endproperty
   a_guard_off: assert property (p_guard_off) else $error("guard error while disabled");
   property p_sync_off;
      $rose(sync_timeout_error) |-> $past(sint_q) != 16'h0000;
   endproperty
   a_sync_off: assert property (p_sync_off) else $error("sync error while disabled");
   property p_emcy_sync;
      emcy_valid && emcy_msg.data[15:0] == 16'h8200 |-> emcy_msg.data[20] && emcy_msg.data[25];
   endproperty
   a_emcy_sync: assert property (p_emcy_sync) else $error("sync emergency layout wrong");
   property p_emcy_hold;
      emcy_valid && !emcy_ready |=> emcy_valid && $stable(emcy_msg);
   endproperty
   a_emcy_hold: assert property (p_emcy_hold) else $error("emergency dropped before taken");
   property p_tx_id;
      tx_valid && tx_req.idx >= 3'h2 |-> tx_req.id >= 11'h380;
   endproperty
   a_tx_id: assert property (p_tx_id) else $error("transmit identifier below 380 hex");
   property p_inhibit;
      tx_valid && tx_ready && tt_q[tx_req.idx] == 8'hFF |-> ##1 ic_q[$past(tx_req.idx)] != 16'h0000
         || inh_q[$past(tx_req.idx)] == 16'h0000 || tv_q;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("inhibit not running after send");

endmodule // css_supervision
`default_nettype wire

// ==== verif/css_master_model.sv ====
// Purpose: network master stand-in facing the supervision block
// Assumes: go_* are one-cycle requests from the bench
// Notes:   slow mode holds ready back for three cycles after each rise of valid
`timescale 1ns/1ps
`default_nettype none
module css_master_model (
   // Clock, reset and bench requests
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic go_sync,
   input  wire logic go_reset,
   input  wire logic slow,
   // Block handshakes
   input  wire logic emcy_valid,
   input  wire logic tx_valid,
   output logic      sync_rx,
   output logic      guard_rx,
   output logic      nmt_reset_cmd,
   output logic      emcy_ready,
   output logic      tx_ready
);
   logic [1:0] e_q;
   logic [1:0] t_q;
   // master never guards, so any nonzero guard interval runs out
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {sync_rx, guard_rx, nmt_reset_cmd, e_q, t_q} <= '0;
      end else begin
         {sync_rx, guard_rx, nmt_reset_cmd} <= {go_sync, 1'b0, go_reset};
         e_q <= emcy_valid ? e_q + {1'b0, e_q != 2'h3} : 2'h0;
         t_q <= tx_valid ? t_q + {1'b0, t_q != 2'h3} : 2'h0;
      end
   end
   // Slow sink waits before taking, as a busy bus would
   assign emcy_ready = emcy_valid & (!slow | e_q == 2'h3);
   assign tx_ready   = tx_valid & (!slow | t_q == 2'h3);
endmodule // css_master_model
`default_nettype wire

// ==== verif/css_supervision_bench.sv ====
// Purpose: self-checking bench of the supervision block
// Assumes: MS_CYC shortened to 4 cycles per ms
// Notes:   outputs are read at the edge, before it updates them
`timescale 1ns/1ps
`default_nettype none
module css_supervision_bench;
   logic hclk, hresetn = 0, hsel = 0, hwrite = 0, slow = 0, go_sync = 0, go_reset = 0, err_supply = 0;
   logic [31:0] haddr = '0, hwdata = '0, q, hrdata;
   logic [1:0]  htrans = '0;
   logic [23:0] wire_break = '0, short_circ = '0;
   logic [7:0]  tx_change = '0, error_register;
   logic [5:0]  node_number;
   logic hready, hreadyout, hresp, sync_rx, guard_rx, nmt_reset_cmd, emcy_valid, emcy_ready, tx_valid, tx_ready;
   logic reset_node_request_flag, software_restart_call, guard_timeout_error, sync_timeout_error, sync_pulse_flag;
   css_pkg::css_emcy_s  emcy_msg;
   css_pkg::css_txreq_s tx_req;
   int fails = 0, n_checks = 0;
   wire [6:0] ev = {hready, !emcy_valid, sync_timeout_error, reset_node_request_flag, tx_valid, emcy_valid,
                    sync_pulse_flag};
   assign hready = hreadyout;
   css_supervision #(.MS_CYC(4)) css_supervision_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata, .nmt_reset_cmd, .guard_rx, .sync_rx,
      .err_general(1'b0), .err_supply, .err_overtemp(1'b0), .wire_break, .short_circ, .tx_change,
      .emcy_valid, .emcy_msg, .emcy_ready, .tx_valid, .tx_req, .tx_ready, .reset_node_request_flag,
      .software_restart_call, .guard_timeout_error, .sync_timeout_error, .sync_pulse_flag, .error_register,
      .node_number);
   css_master_model css_master_model_i (.hclk, .hresetn, .go_sync, .go_reset, .slow, .emcy_valid,
      .tx_valid, .sync_rx, .guard_rx, .nmt_reset_cmd, .emcy_ready, .tx_ready);
   // Clock at 250 MHz
   initial begin
      hclk = 0;
      forever #2 hclk = ~hclk;
   end
   task test_done;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // Bounded wait for one event bit, sampled at the edge
   task wt(input int k);
      for (int i = 0; i < 60; i++) begin
         @(posedge hclk);
         if (ev[k] === 1'b1) return;
      end
      fails++;
      $display("Error wait %0d expected 1 seen 0", k);
      test_done();
   endtask
   // One AHB single transfer; each phase held until hready
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      wt(6);
      htrans <= 2'b00;
      hwdata <= d;
      wt(6);
      q = hrdata;
   endtask
   task t_node;
      bus(0, 8'h04, 0);
      chk("node_rst", 32'h20, q);
      chk("hresp", 0, hresp);
      bus(1, 8'h04, 31);
      chk("node_31", 6'h20, node_number);
      bus(1, 8'h04, 5);
      chk("node_5", 6'h05, node_number);
      $display("node test done");
   endtask
   task t_reset;
      go_reset <= 1;
      @(posedge hclk);
      go_reset <= 0;
      wt(3);
      bus(1, 8'h00, 3);
      chk("restart", 1, software_restart_call);
      bus(0, 8'h00, 0);
      chk("rst_clr", 0, q[0]);
      $display("reset test done");
   endtask
   task t_sync;
      go_sync <= 1;
      @(posedge hclk);
      go_sync <= 0;
      wt(0);
      @(posedge hclk);
      chk("sync_len", 0, sync_pulse_flag);
      $display("sync test done");
   endtask
   task t_tx;
      tx_change <= 8'h05;
      @(posedge hclk);
      tx_change <= 0;
      wt(2);
      chk("tx1", {3'd0, 11'h185}, tx_req);
      wt(2);
      chk("tx3", {3'd2, 11'h38A}, tx_req);
      $display("tx test done");
   endtask
   // Second change inside the inhibit delay must wait for it
   task t_inh;
      bus(1, 8'h1C, 32'h00030002);
      tx_change <= 8'h08;
      @(posedge hclk);
      tx_change <= 0;
      wt(2);
      chk("inh_first", {3'd3, 11'h38B}, tx_req);
      tx_change <= 8'h08;
      @(posedge hclk);
      tx_change <= 0;
      repeat (2) @(posedge hclk);
      chk("inh_hold", 0, tx_valid);
      wt(2);
      chk("inh_after", {3'd3, 11'h38B}, tx_req);
      $display("inhibit test done");
   endtask
   task t_emcy;
      err_supply <= 1;
      wt(1);
      chk("emcy_id", 11'h0A0, emcy_msg.id);
      chk("supply", 24'h043200, emcy_msg.data[23:0]);
      wt(5);
      slow <= 1;
      wire_break <= 24'h030201;
      wt(1);
      chk("wire", 32'h03020106, emcy_msg.data[47:16]);
      chk("wire_code", 16'h2100, emcy_msg.data[15:0]);
      wt(5);
      short_circ <= 24'h800400;
      wt(1);
      chk("short", 32'h80040006, emcy_msg.data[47:16]);
      chk("short_code", 16'h2300, emcy_msg.data[15:0]);
      wt(5);
      bus(1, 8'h0C, 2);
      wt(4);
      wt(1);
      chk("sync_err", 32'h02168200, emcy_msg.data[31:0]);
      bus(1, 8'h08, 32'h00010001);
      repeat (8) @(posedge hclk);
      bus(0, 8'h10, 0);
      chk("stat", 32'h00001603, q);
      chk("err_reg", 8'h16, error_register);
      $display("emergency test done");
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1;
      hsel <= 1;
      t_node();
      t_reset();
      t_sync();
      t_tx();
      t_inh();
      t_emcy();
      test_done();
   end
endmodule // css_supervision_bench
`default_nettype wire
